// [sleep_wakeup_pkg.sv]
package sleep_wakeup_pkg;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PC_W = 11;
    localparam logic [7:0] WAKE_MASK_RST = 8'hff;
    localparam logic [7:0] WAKE_EDGE_RST = 8'hff;
    localparam logic [PC_W-1:0] PC_RESET_VEC = 11'h7ff;
    localparam logic [PC_W-1:0] PC_IRQ_VEC = 11'h000;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // ------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------
    localparam int ST_PD_BIT = 3;
    localparam int ST_TO_BIT = 4;
    localparam int ST_PAGE_LO = 5;
    // ------------------------------------------------------------
    // Mode select codes for port-register moves on Port B
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_PENDING = 4'h9;
    localparam logic [3:0] MODE_EDGE = 4'ha;
    localparam logic [3:0] MODE_MASK = 4'hb;
    localparam logic [3:0] MODE_DIR = 4'hf;
    localparam logic [7:0] DIR_RST = 8'hff;

    typedef enum logic [1:0] {
        RUN,
        ASLEEP,
        IN_IRQ
    } core_state_t;
endpackage

// [sleep_wakeup_interrupt_unit.sv]
`timescale 1ns/100ps
// Contract
// - Sleep instruction stops all but watchdog
// - Sleep with watchdog: clear counter, set flags
// - Wake on watchdog, enabled edge, reset pin
// - Enable mask bits active low, any combination
// - Edge select one falling, zero rising
// - Reset loads ones into mask and edge
// - Selected edge latches sticky pending bit
// - Wakeup sends program counter to top address
// - Pending bits not initialised on reset (code clears them to zero)
// - Port B pending move swaps with accumulator
// - Counter wrap raises gated internal interrupt
// - Port B pins are edge interrupt sources
// - Acknowledged interrupt blocks others until return
// - Entry saves pc, pointer, status, accumulator
// - Clear page bits after status saved
// - Interrupt stack separate from call stack
// - Interrupt vector is address zero
// - No priority, interrupts handled one at a time
// - Edge during service sets pending, no trigger
// - Return restores shadows; variant adds to counter
module sleep_wakeup_interrupt_unit
    import sleep_wakeup_pkg::*;
#(
    parameter int PINS = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Port B pins and external reset pin level
    input wire logic [PINS-1:0] port_b_data,
    input wire logic external_reset_pin,
    // Core instruction strobes
    input wire logic sleep_exec,
    input wire logic return_from_irq,
    input wire logic return_irq_add_acc,
    input wire logic port_move,
    input wire logic port_is_b,
    input wire logic [3:0] mode_sel,
    input wire logic irq_enable_opt,
    // Core state to save and restore
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [7:0] fsr_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] realtime_counter,
    input wire logic counter_tick,
    // Watchdog
    input wire logic watchdog_enable,
    input wire logic watchdog_overflow,
    output logic watchdog_clear,
    // Core controls
    output logic pc_load,
    output logic [PC_W-1:0] pc_out,
    output logic state_load,
    output logic [7:0] fsr_out,
    output logic [7:0] status_out,
    output logic [7:0] acc_out,
    output logic counter_load,
    output logic [7:0] counter_out,
    output logic core_halt,
    output logic irq_active,
    // Port B register view
    output logic [PINS-1:0] wake_enable_mask,
    output logic [PINS-1:0] wake_edge_select,
    output logic [PINS-1:0] wake_pending_bits,
    output logic [PINS-1:0] port_b_dir
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        core_state_t st;
        // Synchronisers and edge history
        logic [PINS-1:0] s1;
        logic [PINS-1:0] s2;
        logic [PINS-1:0] prev;
        logic mclr1;
        logic mclr2;
        // Port B control registers
        logic [PINS-1:0] mask;
        logic [PINS-1:0] edge_sel;
        logic [PINS-1:0] pend;
        logic [PINS-1:0] dir;
        // Interrupt stack and shadows
        logic [PC_W-1:0] pc_stack;
        logic [7:0] fsr_sh;
        logic [7:0] st_sh;
        logic [7:0] acc_sh;
        // Wrap detector history
        logic [7:0] cnt_prev;
        // Registered core controls
        logic halt;
        logic busy;
        logic wd_clr;
        logic pc_ld;
        logic [PC_W-1:0] pc_v;
        logic st_ld;
        logic [7:0] fsr_v;
        logic [7:0] status_v;
        logic [7:0] acc_v;
        logic cnt_ld;
        logic [7:0] cnt_v;
    } regs_t;

    regs_t q;
    regs_t d;
    logic [PINS-1:0] edge_hit;
    logic ext_irq;
    logic int_irq;

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // Only s2 and prev feed the detector; s1 stays a pure synchroniser.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_edge
            // Falling when select bit set, rising when clear
            assign edge_hit[g] = q.edge_sel[g] ? (q.prev[g] & ~q.s2[g])
                                               : (~q.prev[g] & q.s2[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // Trigger sources
    // ------------------------------------------------------------
    // Active-low mask enables each pin independently
    assign ext_irq = |(edge_hit & ~q.mask);
    assign int_irq = irq_enable_opt &&
                     counter_tick &&
                     q.cnt_prev == CNT_MAX &&
                     realtime_counter == 8'h00;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        // --------------------------------------------------------
        // Defaults
        // --------------------------------------------------------
        // Pulses last one cycle unless set again below
        d = q;
        d.s1 = port_b_data;
        d.s2 = q.s1;
        d.prev = q.s2;
        d.mclr1 = external_reset_pin;
        d.mclr2 = q.mclr1;
        d.cnt_prev = realtime_counter;
        d.wd_clr = 1'b0;
        d.pc_ld = 1'b0;
        d.st_ld = 1'b0;
        d.cnt_ld = 1'b0;

        // --------------------------------------------------------
        // Port B register moves
        // --------------------------------------------------------
        // Software write of Port B control registers via mode code
        if (port_move && port_is_b) begin
            case (mode_sel)
                MODE_PENDING: begin
                    d.pend = acc_in;
                    d.acc_v = q.pend;
                    d.fsr_v = fsr_in;
                    d.status_v = status_in;
                    d.st_ld = 1'b1;
                end
                MODE_EDGE: begin
                    d.edge_sel = acc_in;
                end
                MODE_MASK: begin
                    d.mask = acc_in;
                end
                MODE_DIR: begin
                    d.dir = acc_in;
                end
                default: begin
                    // Unknown codes leave every register alone
                    d.dir = q.dir;
                end
            endcase
        end

        // --------------------------------------------------------
        // Pending capture
        // --------------------------------------------------------
        // Edge sets win over a software clear in the same cycle
        d.pend = d.pend | edge_hit;

        // --------------------------------------------------------
        // Sequencer
        // --------------------------------------------------------
        // Sleep outranks a trigger arriving in the same cycle
        case (q.st)
            RUN: begin
                if (sleep_exec) begin
                    d.st = ASLEEP;
                    if (watchdog_enable) begin
                        d.wd_clr = 1'b1;
                        d.status_v = status_in;
                        d.status_v[ST_TO_BIT] = 1'b1;
                        d.status_v[ST_PD_BIT] = 1'b0;
                        d.fsr_v = fsr_in;
                        d.acc_v = acc_in;
                        d.st_ld = 1'b1;
                    end
                end else if (ext_irq || int_irq) begin
                    // One shared entry path: no source outranks another
                    d.st = IN_IRQ;
                    // Shadows hold the values of the code being left
                    d.pc_stack = pc_in;
                    d.fsr_sh = fsr_in;
                    d.st_sh = status_in;
                    d.acc_sh = acc_in;
                    d.status_v = status_in;
                    d.status_v[ST_PAGE_LO+:3] = 3'b000;
                    d.fsr_v = fsr_in;
                    d.acc_v = acc_in;
                    d.st_ld = 1'b1;
                    d.pc_v = PC_IRQ_VEC;
                    d.pc_ld = 1'b1;
                end
            end

            ASLEEP: begin
                if (watchdog_overflow || ext_irq || q.mclr2) begin
                    d.st = RUN;
                    d.pc_v = PC_RESET_VEC;
                    d.pc_ld = 1'b1;
                end
            end

            IN_IRQ: begin
                // Edges here only update pending; no new entry
                if (return_from_irq || return_irq_add_acc) begin
                    d.st = RUN;
                    d.pc_v = q.pc_stack;
                    d.pc_ld = 1'b1;
                    d.fsr_v = q.fsr_sh;
                    d.status_v = q.st_sh;
                    d.acc_v = q.acc_sh;
                    d.st_ld = 1'b1;
                    // Sum wraps in eight bits like the counter itself
                    if (return_irq_add_acc) begin
                        d.cnt_v = realtime_counter + q.acc_sh;
                        d.cnt_ld = 1'b1;
                    end
                end
            end

            default: d.st = RUN;
        endcase

        // --------------------------------------------------------
        // Registered state views
        // --------------------------------------------------------
        // Decoding here keeps both outputs glitch free at the core
        d.halt = (d.st == ASLEEP);
        d.busy = (d.st == IN_IRQ);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Pending bits are cleared for a repeatable start;
    // software must still clear them before enabling
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.mask <= WAKE_MASK_RST;
            q.edge_sel <= WAKE_EDGE_RST;
            q.dir <= DIR_RST;
            q.pend <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign watchdog_clear = q.wd_clr;
    assign pc_load = q.pc_ld;
    assign pc_out = q.pc_v;
    assign state_load = q.st_ld;
    assign fsr_out = q.fsr_v;
    assign status_out = q.status_v;
    assign acc_out = q.acc_v;
    assign counter_load = q.cnt_ld;
    assign counter_out = q.cnt_v;
    // State views come from their own flops, not a decode
    assign core_halt = q.halt;
    assign irq_active = q.busy;
    assign wake_enable_mask = q.mask;
    assign wake_edge_select = q.edge_sel;
    assign wake_pending_bits = q.pend;
    assign port_b_dir = q.dir;
endmodule

// [sleep_wakeup_chk.sv]
`timescale 1ns/100ps
module sleep_wakeup_chk
    import sleep_wakeup_pkg::*;
#(
    parameter int PINS = 8
) (
    // Unit inputs
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic sleep_exec,
    input wire logic return_from_irq,
    input wire logic return_irq_add_acc,
    input wire logic port_move,
    input wire logic port_is_b,
    input wire logic [3:0] mode_sel,
    input wire logic [7:0] acc_in,
    input wire logic watchdog_enable,
    // Unit outputs
    input wire logic watchdog_clear,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic state_load,
    input wire logic [7:0] status_out,
    input wire logic counter_load,
    input wire logic core_halt,
    input wire logic irq_active,
    input wire logic [PINS-1:0] wake_enable_mask,
    input wire logic [PINS-1:0] wake_pending_bits
);
    // ----
    // Properties
    // ----
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic run;
    assign run = !core_halt && !irq_active;
    sequence entry_s; $rose(irq_active); endsequence
    sequence ret_s; irq_active && (return_from_irq || return_irq_add_acc);
    endsequence
    sequence sleep_s; sleep_exec && run; endsequence
    irq_vec_a: assert property (
        entry_s |-> pc_load && pc_out == PC_IRQ_VEC)
        else $error("irq entry not at vector zero");
    page_clear_a: assert property (
        entry_s |-> state_load && !status_out[7:5])
        else $error("page bits kept on irq entry");
    irq_block_a: assert property (
        irq_active && !(return_from_irq || return_irq_add_acc)
        |=> irq_active)
        else $error("service left without return");
    ret_restore_a: assert property (
        ret_s |=> !irq_active && pc_load && state_load)
        else $error("return did not restore");
    add_ret_a: assert property (
        counter_load |-> $past(return_irq_add_acc))
        else $error("counter load without add return");
    sleep_halt_a: assert property (sleep_s |=> core_halt)
        else $error("sleep did not halt");
    wdog_clear_a: assert property (sleep_s and watchdog_enable |=>
        watchdog_clear && state_load && status_out[4:3] == 2'b10)
        else $error("sleep with watchdog flags wrong");
    wake_vec_a: assert property (
        $fell(core_halt) |-> pc_load && pc_out == PC_RESET_VEC)
        else $error("wake not at top address");
    sticky_pend_a: assert property (
        !$past(port_move && mode_sel == MODE_PENDING)
        |-> ($past(wake_pending_bits) & ~wake_pending_bits) == '0)
        else $error("pending bit dropped by itself");
    mask_write_a: assert property (
        port_move && port_is_b && mode_sel == MODE_MASK
        |=> wake_enable_mask == $past(acc_in))
        else $error("mask write lost");
endmodule

// [port_b_pins.sv]
`timescale 1ns/100ps
module port_b_pins (
    // Clock and requested levels
    input wire logic core_clk,
    input wire logic [7:0] want,
    // Pins seen by the unit
    output logic [7:0] port_b_data
);
    // Moving off the edge exercises the unit's synchroniser
    initial port_b_data = 8'h00;
    always @(posedge core_clk) port_b_data <= #2 want;
endmodule

// [sleep_wakeup_interrupt_unit_tb.sv]
`timescale 1ns/100ps
module sleep_wakeup_interrupt_unit_tb;
    import sleep_wakeup_pkg::*;
    // ----
    // Signals
    // ----
    logic core_clk = 1'b0, rst_b = 1'b0, external_reset_pin = 1'b0;
    logic sleep_exec = 1'b0, return_from_irq = 1'b0, return_irq_add_acc = 1'b0;
    logic port_move = 1'b0, port_is_b = 1'b1, irq_enable_opt = 1'b0;
    logic counter_tick = 1'b0, watchdog_enable = 1'b0, watchdog_overflow = 1'b0;
    logic [3:0] mode_sel = 4'h0;
    logic [PC_W-1:0] pc_in = 11'h123, pc_out;
    logic [7:0] fsr_in = 8'h44, status_in = 8'hfd, acc_in = 8'h3c, want = 8'h00;
    logic [7:0] realtime_counter = 8'h00, port_b_data, fsr_out, status_out;
    logic [7:0] acc_out, counter_out, wake_enable_mask, wake_edge_select;
    logic [7:0] wake_pending_bits, port_b_dir;
    logic watchdog_clear, pc_load, state_load, counter_load, core_halt;
    logic irq_active;
    int bad_count = 0;
    int compares = 0;
    sleep_wakeup_interrupt_unit dut(.*);
    port_b_pins pins(.core_clk(core_clk), .want(want), .port_b_data(port_b_data));
    always #2 core_clk = ~core_clk;
    // ----
    // Helpers
    // ----
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic move(input logic [3:0] m, input logic [7:0] v,
                        output logic [8:0] s);
        port_move = 1'b1;
        mode_sel = m;
        acc_in = v;
        tick;
        s = {state_load, acc_out};
        port_move = 1'b0;
        tick;
    endtask
    task automatic wait_pc;
        int n;
        n = 0;
        while (pc_load !== 1'b1 && n < 20) begin
            tick;
            n++;
        end
        check(n < 20, 1'b1);
    endtask
    task automatic quiet(input int k);
        int n;
        n = 0;
        repeat (k) begin
            tick;
            n += pc_load;
        end
        check(n, 0);
    endtask
    task automatic wrap;
        realtime_counter = 8'hff;
        counter_tick = 1'b1;
        tick;
        realtime_counter = 8'h00;
        tick;
        counter_tick = 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_config;
        logic [8:0] s;
        check({wake_enable_mask, wake_edge_select},
              {WAKE_MASK_RST, WAKE_EDGE_RST});
        check({port_b_dir, core_halt}, {DIR_RST, 1'b0});
        move(MODE_EDGE, 8'h0f, s);
        move(4'h3, 8'h00, s);
        move(MODE_PENDING, 8'h00, s);
        move(MODE_MASK, 8'hcf, s);
        move(MODE_DIR, 8'h5a, s);
        check({wake_edge_select, wake_enable_mask}, 16'h0fcf);
        check({port_b_dir, wake_pending_bits}, 16'h5a00);
    endtask
    task automatic t_irq;
        logic [8:0] s;
        acc_in = 8'h3c;
        want = 8'h11;
        wait_pc;
        check({pc_out, status_out}, {PC_IRQ_VEC, 8'h1d});
        check({irq_active, wake_pending_bits}, 9'h110);
        pc_in = 11'h055;
        fsr_in = 8'h00;
        status_in = 8'h00;
        want = 8'h30;
        quiet(8);
        check(wake_pending_bits, 8'h31);
        move(MODE_PENDING, 8'h00, s);
        check({s, wake_pending_bits}, {1'b1, 8'h31, 8'h00});
        return_from_irq = 1'b1;
        tick;
        return_from_irq = 1'b0;
        check({pc_load, pc_out}, {1'b1, 11'h123});
        check({fsr_out, status_out}, 16'h44fd);
        check({acc_out, irq_active}, {8'h3c, 1'b0});
    endtask
    task automatic t_wrap;
        irq_enable_opt = 1'b1;
        acc_in = 8'h3c;
        wrap;
        wait_pc;
        realtime_counter = 8'h05;
        return_irq_add_acc = 1'b1;
        tick;
        return_irq_add_acc = 1'b0;
        check({counter_load, counter_out}, 9'h141);
        irq_enable_opt = 1'b0;
        wrap;
        quiet(8);
    endtask
    task automatic t_sleep;
        want = 8'h00;
        repeat (6) tick;
        for (int i = 0; i < 3; i++) begin
            watchdog_enable = (i == 0);
            sleep_exec = 1'b1;
            tick;
            sleep_exec = 1'b0;
            check({core_halt, watchdog_clear}, {1'b1, i == 0});
            if (i == 0) check({state_load, status_out[4:3]}, 3'b110);
            repeat (4) tick;
            watchdog_overflow = (i == 0);
            external_reset_pin = (i == 1);
            if (i == 2) want = 8'h10;
            wait_pc;
            check({pc_out, core_halt}, {PC_RESET_VEC, 1'b0});
            watchdog_overflow = 1'b0;
            external_reset_pin = 1'b0;
            repeat (6) tick;
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rst_b = 1'b1;
        tick;
        t_config;
        t_irq;
        t_wrap;
        t_sleep;
        report_and_stop;
    end
    initial begin
        #20000;
        bad_count++;
        report_and_stop;
    end
endmodule
bind sleep_wakeup_interrupt_unit sleep_wakeup_chk #(.PINS(PINS)) chk(.*);
